// ===== rtl/srwb_top.sv
// reset sequencer, reset cause, watchdog service and break logic behind an AHB-Lite slave
// assumes haddr byte address = 4 * register index; single word transfers only
`timescale 1ns/1ps
module srwb_top
  import srwb_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe,
  input  wire logic        monitor_mode,
  input  wire logic        rst_pin_high_test_voltage,
  input  wire logic        irq_pin_high_test_voltage,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_addr_valid,
  input  wire logic        cpu_wait,
  output logic             cpu_reset_n,
  output logic             module_clk_en,
  output logic             generated_output_clock_en,
  output logic             break_state,
  output logic             irq
);
  import srwb_pkg::*;

  srwb_cnt_if cif ();

  srwb_sys_counter u_ctr
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cif     (cif.ctr)
  );

  srwb_watchdog u_wd
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cif     (cif.wd)
  );

  srwb_seq_t    seq_reg;
  srwb_seq_t    seq_next;
  logic [REL_BITS-1:0] rel_reg;
  logic         oe_reg;
  logic         cpu_rst_n_reg;
  logic         clk_en_reg;
  logic         cgm_en_reg;
  logic [7:0]   cause_reg;
  logic         bw_reg;
  logic         break_flag_clear_enable_reg;
  logic [7:0]   brk_hi_reg;
  logic [7:0]   brk_lo_reg;
  logic         bke_reg;
  logic         bka_reg;
  logic [1:0]   irq_sts_reg;
  logic [1:0]   irq_mask_reg;
  logic         irq_reg;
  logic [31:0]  rdata_reg;
  logic         wr_pend_reg;
  logic [15:0]  wr_idx_reg;
  logic [31:0]  rd_data;
  logic         addr_ok;
  logic [15:0]  idx;
  logic         acc;
  logic         rd_acc;
  logic         wr_do;
  logic         ext_rst;
  logic         int_rst;
  logic         brk_hit;
  logic         clr_ok;
  logic         hreadyout_q;
  logic         hresp_q;

  // ---------------- reset sequencing ----------------

  // a low seen on the pin while we are not driving it is an external reset
  assign ext_rst = !oe_reg && !rst_pin_i;
  assign int_rst = cif.wd_ovf || ext_rst;
  assign cif.clr = int_rst;
  // only the reset sequence and monitor mode with a test voltage hold the watchdog off, never a register bit
  assign cif.wd_en = (seq_reg == SEQ_RUN)
                  && !(monitor_mode && (rst_pin_high_test_voltage || irq_pin_high_test_voltage));

  always_comb
  begin
    seq_next = seq_reg;
    unique case (seq_reg)
      SEQ_STAB:
      begin
        // leave as the count reaches 4096, so the pin stays low for exactly that many cycles
        if (cif.cnt == SC_BITS'(STAB_CYCLES - 1))
        begin
          seq_next = SEQ_RELEASE;
        end
      end
      SEQ_RELEASE:
      begin
        if (rel_reg == REL_BITS'(RELEASE_CYCLES - 1))
        begin
          seq_next = SEQ_RUN;
        end
      end
      SEQ_RUN:
      begin
        seq_next = SEQ_RUN;
      end
    endcase
    if (int_rst)
    begin
      seq_next = SEQ_STAB;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seq_reg <= SEQ_STAB;
      rel_reg <= '0;
    end
    else
    begin
      seq_reg <= seq_next;
      rel_reg <= (seq_next == SEQ_RELEASE && seq_reg == SEQ_RELEASE) ? rel_reg + 1'b1 : '0;
    end
  end

  // outputs follow the next state so they change in step with the state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oe_reg        <= 1'b1;
      cpu_rst_n_reg <= 1'b0;
      clk_en_reg    <= 1'b0;
      cgm_en_reg    <= 1'b1;
    end
    else
    begin
      oe_reg        <= (seq_next == SEQ_STAB);
      cpu_rst_n_reg <= (seq_next == SEQ_RUN);
      clk_en_reg    <= (seq_next != SEQ_STAB);
      cgm_en_reg    <= 1'b1;
    end
  end

  // cause bits survive internal resets; only power-on clears them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cause_reg <= CAUSE_POR_VAL;
    end
    else
    begin
      if (cif.wd_ovf)
      begin
        cause_reg[CAUSE_WD_BIT] <= 1'b1;
      end
      if (ext_rst)
      begin
        cause_reg[CAUSE_PIN_BIT] <= 1'b1;
      end
    end
  end

  // ---------------- AHB-Lite slave ----------------

  assign idx     = haddr[17:2];
  assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
  assign acc     = hsel && htrans[1] && hready;
  assign rd_acc  = acc && !hwrite && addr_ok;
  assign wr_do   = wr_pend_reg;
  // interrupt status bits stay put on reads during break unless software allowed clearing
  assign clr_ok  = !bka_reg || break_flag_clear_enable_reg;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (addr_ok)
    begin
      unique case (idx)
        IDX_BRK_STATUS:  rd_data[BW_BIT] = bw_reg;
        IDX_RST_CAUSE:   rd_data[7:0] = cause_reg;
        IDX_BRK_FCLR:    rd_data[BREAK_FLAG_CLEAR_ENABLE_BIT] = break_flag_clear_enable_reg;
        IDX_BRK_ADDR_HI: rd_data[7:0] = brk_hi_reg;
        IDX_BRK_ADDR_LO: rd_data[7:0] = brk_lo_reg;
        IDX_BRK_CTRL:    rd_data[7:0] = {bke_reg, bka_reg, 6'h00};
        IDX_IRQ_STATUS:  rd_data[1:0] = irq_sts_reg;
        IDX_IRQ_MASK:    rd_data[1:0] = irq_mask_reg;
        default:         rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_reg   <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 16'h0000;
    end
    else
    begin
      rdata_reg   <= rd_acc ? rd_data : 32'h0000_0000;
      wr_pend_reg <= acc && hwrite && addr_ok;
      wr_idx_reg  <= idx;
    end
  end

  // zero wait states; every answer is OKAY, unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  // watchdog service: any value, taken in the write data phase
  assign cif.svc = wr_do && (wr_idx_reg == IDX_WD_SERVICE);

  // ---------------- break logic ----------------

  assign brk_hit = bke_reg && cpu_addr_valid && (cpu_addr == {brk_hi_reg, brk_lo_reg});

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      break_flag_clear_enable_reg   <= 1'b0;
      brk_hi_reg <= REG8_RST;
      brk_lo_reg <= REG8_RST;
      bke_reg    <= 1'b0;
    end
    else if (wr_do)
    begin
      if (wr_idx_reg == IDX_BRK_FCLR)
      begin
        break_flag_clear_enable_reg <= hwdata[BREAK_FLAG_CLEAR_ENABLE_BIT];
      end
      if (wr_idx_reg == IDX_BRK_ADDR_HI)
      begin
        brk_hi_reg <= hwdata[7:0];
      end
      if (wr_idx_reg == IDX_BRK_ADDR_LO)
      begin
        brk_lo_reg <= hwdata[7:0];
      end
      if (wr_idx_reg == IDX_BRK_CTRL)
      begin
        bke_reg <= hwdata[BKE_BIT];
      end
    end
  end

  // break entry wins over a clearing write in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bka_reg <= 1'b0;
      bw_reg  <= 1'b0;
    end
    else
    begin
      if (brk_hit)
      begin
        bka_reg <= 1'b1;
      end
      else if (wr_do && wr_idx_reg == IDX_BRK_CTRL && !hwdata[BKA_BIT])
      begin
        bka_reg <= 1'b0;
      end
      if (brk_hit && cpu_wait)
      begin
        bw_reg <= 1'b1;
      end
      else if (wr_do && wr_idx_reg == IDX_BRK_STATUS && !hwdata[BW_BIT])
      begin
        bw_reg <= 1'b0;
      end
    end
  end

  // ---------------- interrupts ----------------

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_sts_reg  <= 2'h0;
      irq_mask_reg <= 2'h0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == IRQ_BRK_BIT && brk_hit && !bka_reg) || (i == IRQ_WD_BIT && cif.wd_ovf))
        begin
          irq_sts_reg[i] <= 1'b1;
        end
        else if (rd_acc && idx == IDX_IRQ_STATUS && clr_ok)
        begin
          irq_sts_reg[i] <= 1'b0;
        end
      end
      if (wr_do && wr_idx_reg == IDX_IRQ_MASK)
      begin
        irq_mask_reg <= hwdata[1:0];
      end
      irq_reg <= |(irq_sts_reg & irq_mask_reg);
    end
  end

  assign hrdata                    = rdata_reg;
  assign hreadyout                 = hreadyout_q;
  assign hresp                     = hresp_q;
  assign rst_pin_o                 = 1'b0;
  assign rst_pin_oe                = oe_reg;
  assign cpu_reset_n               = cpu_rst_n_reg;
  assign module_clk_en             = clk_en_reg;
  assign generated_output_clock_en = cgm_en_reg;
  assign break_state               = bka_reg;
  assign irq                       = irq_reg;
endmodule

// ===== rtl/srwb_pkg.sv
// constants, field positions and types for the reset, watchdog and break block
// assumes one clock (hclk) that also serves as the crystal reference clock
// Function
// - hold external reset low while system counter counts 4096 reference cycles
// - after stabilisation wait 64 more cycles, then release processor reset
// - at power-up: internal reset on, output clock on, module clocks off
// - power-on reset sets power-up cause bit and clears all others
// - watchdog overflow makes internal reset and sets watchdog cause bit
// - every internal reset source pulls external reset line low
// - any write to service address clears watchdog and system counter bits 12..4
// - watchdog advances on system counter output, at least every 2^13-2^4 cycles
// - monitor mode with high test voltage on reset or irq pin disables watchdog
// - in break, status reads clear bits only when flag-clear enable is set
// - writing 0 to break-wait flag clears it
package srwb_pkg;
  localparam int unsigned STAB_CYCLES    = 4096;
  localparam int unsigned RELEASE_CYCLES = 64;
  localparam int unsigned SC_BITS        = 13;
  localparam int unsigned SC_SVC_LO      = 4;
  localparam int unsigned WD_BITS        = 8;
  localparam int unsigned REL_BITS       = 6;
  localparam logic [15:0] IDX_BRK_STATUS  = 16'hFE00;
  localparam logic [15:0] IDX_RST_CAUSE   = 16'hFE01;
  localparam logic [15:0] IDX_BRK_FCLR    = 16'hFE03;
  localparam logic [15:0] IDX_BRK_ADDR_HI = 16'hFE0C;
  localparam logic [15:0] IDX_BRK_ADDR_LO = 16'hFE0D;
  localparam logic [15:0] IDX_BRK_CTRL    = 16'hFE0E;
  localparam logic [15:0] IDX_IRQ_STATUS  = 16'hFE10;
  localparam logic [15:0] IDX_IRQ_MASK    = 16'hFE11;
  localparam logic [15:0] IDX_WD_SERVICE  = 16'hFFFF;
  localparam int unsigned BW_BIT        = 1;
  localparam int unsigned BREAK_FLAG_CLEAR_ENABLE_BIT      = 7;
  localparam int unsigned BKE_BIT       = 7;
  localparam int unsigned BKA_BIT       = 6;
  localparam int unsigned CAUSE_POR_BIT = 7;
  localparam int unsigned CAUSE_PIN_BIT = 6;
  localparam int unsigned CAUSE_WD_BIT  = 5;
  localparam int unsigned IRQ_BRK_BIT   = 0;
  localparam int unsigned IRQ_WD_BIT    = 1;
  localparam logic [7:0]  REG8_RST      = 8'h00;
  localparam logic [7:0]  CAUSE_POR_VAL = 8'h80;
  typedef enum logic [1:0] {SEQ_STAB, SEQ_RELEASE, SEQ_RUN} srwb_seq_t;
endpackage

// ===== rtl/srwb_cnt_if.sv
// signals shared by the sequencer, the system counter and the watchdog
// assumes all three sit on hclk
`timescale 1ns/1ps
interface srwb_cnt_if;
  import srwb_pkg::*;
  logic               clr;
  logic               svc;
  logic               tick;
  logic               wd_en;
  logic               wd_ovf;
  logic [SC_BITS-1:0] cnt;
  modport ctr (input clr, input svc, output cnt, output tick);
  modport wd  (input clr, input svc, input tick, input wd_en, output wd_ovf);
  modport ctl (output clr, output svc, output wd_en, input cnt, input tick, input wd_ovf);
endinterface

// ===== rtl/srwb_sys_counter.sv
// free-running 13-bit system counter with a wrap pulse
// assumes clr and svc are one-cycle pulses on hclk
`timescale 1ns/1ps
module srwb_sys_counter
  import srwb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  srwb_cnt_if.ctr  cif
);
  logic [SC_BITS-1:0] cnt_reg;
  logic               tick_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (cif.clr)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (cif.svc)
    begin
      // keep low bits so the output comes no sooner than 2^13-2^4 cycles on
      cnt_reg  <= {{(SC_BITS-SC_SVC_LO){1'b0}}, cnt_reg[SC_SVC_LO-1:0]};
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_reg + 1'b1;
      tick_reg <= &cnt_reg;
    end
  end

  assign cif.cnt  = cnt_reg;
  assign cif.tick = tick_reg;
endmodule

// ===== rtl/srwb_watchdog.sv
// watchdog counter advanced by the system counter output
// assumes wd_en already carries the monitor-mode disable
`timescale 1ns/1ps
module srwb_watchdog
  import srwb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  srwb_cnt_if.wd   cif
);
  logic [WD_BITS-1:0] wd_reg;
  logic               ovf_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wd_reg  <= '0;
      ovf_reg <= 1'b0;
    end
    else if (cif.clr || cif.svc || !cif.wd_en)
    begin
      wd_reg  <= '0;
      ovf_reg <= 1'b0;
    end
    else
    begin
      ovf_reg <= cif.tick && (&wd_reg);
      if (cif.tick)
      begin
        wd_reg <= wd_reg + 1'b1;
      end
    end
  end

  assign cif.wd_ovf = ovf_reg;
endmodule

// ===== tb/srwb_assertions.sv
// port checks for srwb_top: reset sequence, pin pull, bus answer, break
// assumes one hclk domain with hresetn as its asynchronous reset
`timescale 1ns/1ps
module srwb_assertions
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rst_pin_i,
  input wire logic        rst_pin_oe,
  input wire logic        cpu_addr_valid,
  input wire logic        cpu_reset_n,
  input wire logic        module_clk_en,
  input wire logic        generated_output_clock_en,
  input wire logic        break_state
);
  logic [12:0] oe_cnt;
  logic        taken;
  logic        wr_taken;
  assign taken    = hsel && htrans[1] && hready;
  assign wr_taken = taken && hwrite;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // 4096 is far beyond a repetition count, so a counter tracks it
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      oe_cnt <= 13'h0000;
    else if (!rst_pin_oe)
      oe_cnt <= 13'h0000;
    else if (oe_cnt != 13'h1FFF)
      oe_cnt <= oe_cnt + 13'h0001;
  sequence s_stab_end;
    $fell(rst_pin_oe);
  endsequence
  sequence s_cpu_release;
    ##63 !cpu_reset_n ##1 cpu_reset_n;
  endsequence
  chk_stab_count: assert property (s_stab_end |-> oe_cnt == 13'h1000)
    else $error("reset pin released after wrong count");
  chk_clk_enable: assert property (s_stab_end |-> $rose(module_clk_en))
    else $error("module clocks not started with pin release");
  chk_cpu_release: assert property (s_stab_end |-> s_cpu_release)
    else $error("processor released at wrong time");
  chk_held_inactive: assert property (rst_pin_oe |-> !cpu_reset_n && !module_clk_en && generated_output_clock_en)
    else $error("clocks or processor active while pin driven");
  chk_pin_pull: assert property (!rst_pin_i && !rst_pin_oe |-> ##[1:2] (rst_pin_oe && !cpu_reset_n))
    else $error("internal reset did not pull the pin");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_rdata_idle: assert property (!$past(taken) |-> hrdata == 32'h0)
    else $error("read data outside a data phase");
  chk_break_cause: assert property ($rose(break_state) |-> $past(cpu_addr_valid))
    else $error("break entered without a bus address");
  chk_break_clear: assert property ($fell(break_state) |-> $past(wr_taken, 2))
    else $error("break left without a register write");
endmodule
bind srwb_top srwb_assertions u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .rst_pin_i, .rst_pin_oe, .cpu_addr_valid, .cpu_reset_n, .module_clk_en, .generated_output_clock_en,
  .break_state);

// ===== tb/srwb_pin_model.sv
// board around the reset pin: pull-up, push button and test voltage source
// assumes press and voltage requests come from the bench on hclk edges
`timescale 1ns/1ps
module srwb_pin_model
(
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe,
  input  wire logic press,
  input  wire logic hv_rst_req,
  input  wire logic hv_irq_req,
  output logic      rst_pin_i,
  output logic      rst_pin_hv,
  output logic      irq_pin_hv
);
  // device pull-down wins over button and pull-up
  assign rst_pin_i  = rst_pin_oe ? rst_pin_o : !press;
  // test voltage cannot stand on a pin held low
  assign rst_pin_hv = hv_rst_req && !rst_pin_oe && !press;
  assign irq_pin_hv = hv_irq_req;
endmodule

// ===== tb/test_srwb_top.sv
// self-checking bench for srwb_top: power-up, registers, break, pin and power-on resets
// assumes the pin model on the reset line; watchdog expiry (about 2M cycles) is out of reach
`timescale 1ns/1ps
module test_srwb_top;
  import srwb_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, lfsr;
  logic        rst_pin_i, rst_pin_o, rst_pin_oe, rst_hv, irq_hv, press, hv_rst_req, hv_irq_req, monitor_mode;
  logic [15:0] cpu_addr, brk_a;
  logic        cpu_addr_valid, cpu_wait, cpu_reset_n, module_clk_en, gclk_en, break_state, irq;
  logic [15:0] rw_idx [3];
  logic [7:0]  rw_msk [3];
  int          failures, compares, n, k;

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  srwb_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .monitor_mode(monitor_mode),
    .rst_pin_high_test_voltage(rst_hv), .irq_pin_high_test_voltage(irq_hv), .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid), .cpu_wait(cpu_wait), .cpu_reset_n(cpu_reset_n),
    .module_clk_en(module_clk_en), .generated_output_clock_en(gclk_en), .break_state(break_state), .irq(irq));
  srwb_pin_model board (.rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .press(press), .hv_rst_req(hv_rst_req),
    .hv_irq_req(hv_irq_req), .rst_pin_i(rst_pin_i), .rst_pin_hv(rst_hv), .irq_pin_hv(irq_hv));

  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] exp_rw(input logic [31:0] w, input logic [7:0] m);
    return {24'h000000, w[7:0] & m};
  endfunction
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // hready is sampled at each edge, so wait states would be honoured
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0000, idx, 2'h0};
    @(posedge hclk);
    while (hready !== 1'h1)
      @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'h1)
      @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h00000000);
    check(what, rd, exp);
  endtask
  task automatic hit(input logic [15:0] a);
    @(posedge hclk);
    cpu_addr <= a;
    cpu_addr_valid <= 1'h1;
    @(posedge hclk);
    cpu_addr_valid <= 1'h0;
    cpu_addr <= ~a;
    #1;
  endtask
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic seq_check(input int start);
    n = start;
    while (rst_pin_oe === 1'h1)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    check("stab cycles", n, STAB_CYCLES);
    check("clocks", {gclk_en, module_clk_en, cpu_reset_n}, 3'h6);
    n = 0;
    while (cpu_reset_n !== 1'h1)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    check("release cycles", n, RELEASE_CYCLES);
  endtask

  initial
  begin
    repeat (60000) @(posedge hclk);
    failures++;
    summarize();
  end

  initial
  begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {press, hv_rst_req, hv_irq_req, monitor_mode, cpu_addr, cpu_addr_valid, cpu_wait} = '0;
    hsize = 3'h2;
    failures = 0;
    compares = 0;
    lfsr = 32'h6C0C8615;
    rw_idx = '{IDX_BRK_ADDR_HI, IDX_BRK_ADDR_LO, IDX_BRK_FCLR};
    rw_msk = '{8'hFF, 8'hFF, 8'h80};
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    seq_check(0);
    bus(1'h1, IDX_WD_SERVICE, lfsr);
    $display("test power-up done");
    rchk("cause", IDX_RST_CAUSE, {24'h000000, CAUSE_POR_VAL});
    rchk("flag clear", IDX_BRK_FCLR, 32'h00000000);
    rchk("addr high", IDX_BRK_ADDR_HI, 32'h00000000);
    rchk("addr low", IDX_BRK_ADDR_LO, 32'h00000000);
    rchk("break ctrl", IDX_BRK_CTRL, 32'h00000000);
    rchk("break status", IDX_BRK_STATUS, 32'h00000000);
    rchk("unmapped", 16'h0123, 32'h00000000);
    for (int i = 0; i < 12; i++)
    begin
      lfsr = step(lfsr);
      bus(1'h1, rw_idx[i % 3], lfsr);
      rchk("rw reg", rw_idx[i % 3], exp_rw(lfsr, rw_msk[i % 3]));
    end
    $display("test registers done");
    brk_a = lfsr[31:16];
    bus(1'h1, IDX_BRK_ADDR_HI, {24'h000000, brk_a[15:8]});
    bus(1'h1, IDX_BRK_ADDR_LO, {24'h000000, brk_a[7:0]});
    bus(1'h1, IDX_BRK_FCLR, 32'h00000000);
    bus(1'h1, IDX_IRQ_MASK, 32'h00000001);
    hit(brk_a);
    check("break disabled", break_state, 1'h0);
    bus(1'h1, IDX_BRK_CTRL, 32'h00000080);
    cpu_wait <= 1'h1;
    hit(brk_a ^ 16'h0001);
    check("near miss", break_state, 1'h0);
    hit(brk_a);
    check("break entered", break_state, 1'h1);
    rchk("break ctrl", IDX_BRK_CTRL, 32'h000000C0);
    rchk("wait flag", IDX_BRK_STATUS, 32'h00000002);
    check("irq raised", irq, 1'h1);
    rchk("irq kept", IDX_IRQ_STATUS, 32'h00000001);
    rchk("irq kept", IDX_IRQ_STATUS, 32'h00000001);
    bus(1'h1, IDX_BRK_FCLR, 32'h00000080);
    rchk("irq read", IDX_IRQ_STATUS, 32'h00000001);
    rchk("irq cleared", IDX_IRQ_STATUS, 32'h00000000);
    check("irq low", irq, 1'h0);
    bus(1'h1, IDX_BRK_STATUS, 32'h00000000);
    rchk("wait cleared", IDX_BRK_STATUS, 32'h00000000);
    bus(1'h1, IDX_BRK_CTRL, 32'h00000080);
    #1;
    check("break left", break_state, 1'h0);
    cpu_wait <= 1'h0;
    bus(1'h1, IDX_IRQ_MASK, 32'h00000000);
    hit(brk_a);
    check("break again", break_state, 1'h1);
    rchk("no wait flag", IDX_BRK_STATUS, 32'h00000000);
    check("irq masked", irq, 1'h0);
    bus(1'h1, IDX_IRQ_MASK, 32'h00000001);
    settle();
    check("irq unmasked", irq, 1'h1);
    bus(1'h1, IDX_BRK_CTRL, 32'h00000000);
    rchk("irq read", IDX_IRQ_STATUS, 32'h00000001);
    settle();
    check("irq dropped", irq, 1'h0);
    $display("test break done");
    // monitor-mode inputs are driven, but their effect needs a watchdog expiry
    lfsr = step(lfsr);
    monitor_mode <= lfsr[0];
    hv_irq_req <= lfsr[1];
    hv_rst_req <= lfsr[2];
    @(posedge hclk);
    press <= 1'h1;
    n = 0;
    while (rst_pin_oe !== 1'h1)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    check("pull delay", n >= 1 && n <= 2, 1'h1);
    check("pin low", {rst_pin_i, cpu_reset_n}, 2'h0);
    k = lfsr[5:3];
    repeat (k) @(posedge hclk);
    press <= 1'h0;
    seq_check(k);
    bus(1'h0, IDX_RST_CAUSE, 32'h00000000);
    check("pin cause", rd & 32'h00000060, 32'h00000040);
    monitor_mode <= 1'h0;
    $display("test pin reset done");
    @(posedge hclk);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    seq_check(0);
    rchk("cause", IDX_RST_CAUSE, {24'h000000, CAUSE_POR_VAL});
    rchk("addr high", IDX_BRK_ADDR_HI, 32'h00000000);
    $display("test power-on again done");
    summarize();
  end
endmodule
